// *** spew_pkg.sv ***
/*
 * Shared constants and carrier types for the serial EEPROM page-write path.
 * Assumes a single core clock of 250 MHz; link pins arrive asynchronously.
 */
package spew_pkg;
   // Instruction codes, bit 3 is a don't-care and is masked before comparison.
   localparam logic [7:0] OP_MASK = 8'hf7;
   localparam logic [7:0] OP_WRITE = 8'h02;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_STATUS_READ = 8'h05;
   // Status bit positions.
   localparam int ST_BUSY = 0;
   localparam int ST_WEL = 1;
   localparam int ST_PROT_LOW = 2;
   localparam int ST_PROT_HIGH = 3;
   // Programming time in microseconds, a plain default, and its count of core cycles.
   localparam int PROG_TIME_US = 1000;
   localparam int CLK_MHZ = 250;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
   // Reset values.
   localparam logic [2:0] BIT_CNT_RST = 3'h0;
   localparam logic [15:0] ADDR_RST = 16'h0000;

   // One word handed to the array programmer.
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
   } spew_word_t;
endpackage

// *** spew_buf2.sv ***
/*
 * Two-entry valid/ready buffer of flip-flops.
 * Assumes both sides on the same clock.
 */
`timescale 1ns/10ps
module spew_buf2 #(
   parameter int WIDTH = 24
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // Fill side
   input wire logic i_valid,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_ready,
   // Drain side
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   input wire logic i_ready
);
   logic [WIDTH-1:0] mem [2];
   logic [WIDTH-1:0] next_mem [2];
   logic [1:0] count, next_count;
   logic rd, next_rd, wr, next_wr;
   logic push, pop;

   // Full and empty come straight from the count.
   assign o_ready = (count != 2'h2);
   assign o_valid = (count != 2'h0);
   assign o_data = mem[rd];
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;

   // Next pointers, count and storage.
   always_comb begin
      next_mem = mem;
      next_rd = rd ^ pop;
      next_wr = wr ^ push;
      next_count = count + {1'b0, push} - {1'b0, pop};
      if (push) begin
         next_mem[wr] = i_data;
      end
   end

   // Register stage only.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         mem[0] <= '0;
         mem[1] <= '0;
         rd <= 1'b0;
         wr <= 1'b0;
         count <= 2'h0;
      end else begin
         mem <= next_mem;
         rd <= next_rd;
         wr <= next_wr;
         count <= next_count;
      end
   end
endmodule

// *** spew_top.sv ***
/*
 * Write path of a 64K-byte SPI mode 0 serial EEPROM: instruction decode,
 * page-wrapping address, write-enable latch, protection and timed busy.
 * Assumes the link pins are asynchronous to I_CORE_CLK and sampled here,
 * and that the array programmer consumes words from the buffer output.
 */
`timescale 1ns/10ps
// Overview of operation
// - While programming is busy every instruction except status read is ignored.
// - Programming starts only on the select rising edge after a write sequence.
// - Status bit 0 reads 1 while programming runs and 0 after it ends.
// - After each data byte only the seven low address bits increment.
// - Beyond 128 bytes the in-page address wraps and earlier bytes are overwritten.
// - Completion of programming clears the write-enable latch.
// - A write with the latch clear programs nothing and ends in standby on select high.
// - Every instruction begins with a fresh falling edge of select.
// - Input bits are sampled on rising clock and output bits change after falling clock.
// - The write code is 0000 X010 with bit 3 ignored.
// - The latch is clear after reset, so write enable precedes each write.
// - Addresses inside the block-protect range are never programmed.
module spew_top #(
   parameter int PROG_CYCLES = spew_pkg::PROG_CYCLES
) (
   // Core clock and reset
   input wire logic I_CORE_CLK,
   input wire logic I_SYS_RST,
   // Serial link pins
   input wire logic I_CS_N,
   input wire logic I_SCK,
   input wire logic I_SI,
   output logic O_SO,
   output logic O_SO_OE,
   // Block-protect level from the status store
   input wire logic I_BLOCK_PROTECT_LOW_BIT,
   input wire logic I_BLOCK_PROTECT_HIGH_BIT,
   // Words toward the array programmer
   output logic O_WORD_VALID,
   output spew_pkg::spew_word_t O_WORD,
   input wire logic I_WORD_READY,
   // Status
   output logic O_BUSY,
   output logic O_WEL
);
   typedef enum {ST_IDLE, ST_OP, ST_ADH, ST_ADL, ST_DATA, ST_STATUS, ST_SKIP} spew_state_t;

   logic [2:0] cs_s, sck_s;
   logic [1:0] si_s;
   logic cs_n, sck_d, sck_rise, sck_fall, cs_fall, cs_rise;
   spew_state_t state, next_state;
   logic [2:0] bit_cnt, next_bit_cnt;
   logic [7:0] shreg, next_shreg;
   logic [15:0] addr, next_addr;
   logic [7:0] sreg, next_sreg;
   logic wel, next_wel;
   logic pend, next_pend;
   logic busy, next_busy;
   // A wide timer so that any sensible programming time fits without a second stage.
   logic [31:0] tmr, next_tmr;
   logic so, next_so;
   logic soe, next_soe;
   logic push, next_push;
   spew_pkg::spew_word_t word, next_word;
   logic buf_ready;
   logic [7:0] byte_in;
   logic byte_done, prot;

   // Two flops before any logic reads a pin; the third stage feeds edge detect.
   // Only the second flop reads the first, so a metastable first stage never reaches decode.
   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         cs_s <= 3'h7;
         sck_s <= 3'h0;
         si_s <= 2'h0;
      end else begin
         cs_s <= {cs_s[1:0], I_CS_N};
         sck_s <= {sck_s[1:0], I_SCK};
         si_s <= {si_s[0], I_SI};
      end
   end

   assign cs_n = cs_s[1];
   assign sck_d = sck_s[1];
   assign sck_rise = sck_d && !sck_s[2];
   assign sck_fall = !sck_d && sck_s[2];
   assign cs_fall = !cs_n && cs_s[2];
   assign cs_rise = cs_n && !cs_s[2];
   assign byte_in = {shreg[6:0], si_s[1]};
   assign byte_done = sck_rise && !cs_n && (bit_cnt == 3'h7);

   // Protection level decode: none, top quarter, top half, whole array.
   always_comb begin
      case ({I_BLOCK_PROTECT_HIGH_BIT, I_BLOCK_PROTECT_LOW_BIT})
         2'h0: prot = 1'b0;
         2'h1: prot = (addr[15:14] == 2'h3);
         2'h2: prot = addr[15];
         default: prot = 1'b1;
      endcase
   end

   // Sequence decode, address, latch and timer next values.
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_addr = addr;
      next_sreg = sreg;
      next_wel = wel;
      next_pend = pend;
      next_busy = busy;
      next_tmr = tmr;
      next_so = so;
      next_soe = soe;
      next_push = 1'b0;
      next_word = word;
      if (sck_rise && !cs_n) begin
         next_shreg = byte_in;
         next_bit_cnt = bit_cnt + 3'h1;
      end
      // Timed programming; completion drops busy and the latch together.
      if (busy) begin
         if (tmr == 32'h0) begin
            next_busy = 1'b0;
            next_wel = 1'b0;
         end else begin
            next_tmr = tmr - 32'h1;
         end
      end
      case (state)
         ST_IDLE: begin
            next_bit_cnt = spew_pkg::BIT_CNT_RST;
            if (cs_fall) begin
               next_state = ST_OP;
            end
         end
         ST_OP: begin
            if (byte_done) begin
               if ((byte_in & spew_pkg::OP_MASK) == spew_pkg::OP_STATUS_READ) begin
                  next_state = ST_STATUS;
                  next_sreg = busy ? 8'hff : {4'h0, I_BLOCK_PROTECT_HIGH_BIT,
                     I_BLOCK_PROTECT_LOW_BIT, wel, 1'b0};
               end else if (busy) begin
                  next_state = ST_SKIP;
               end else if ((byte_in & spew_pkg::OP_MASK) == spew_pkg::OP_WRITE) begin
                  next_state = ST_ADH;
               end else if ((byte_in & spew_pkg::OP_MASK) == spew_pkg::OP_WRITE_ENABLE) begin
                  next_wel = 1'b1;
                  next_state = ST_SKIP;
               end else if ((byte_in & spew_pkg::OP_MASK) == spew_pkg::OP_WRITE_DISABLE) begin
                  next_wel = 1'b0;
                  next_state = ST_SKIP;
               end else begin
                  next_state = ST_SKIP;
               end
            end
         end
         ST_ADH: begin
            if (byte_done) begin
               next_addr[15:8] = byte_in;
               next_state = ST_ADL;
            end
         end
         ST_ADL: begin
            if (byte_done) begin
               next_addr[7:0] = byte_in;
               next_state = ST_DATA;
            end
         end
         ST_DATA: begin
            if (byte_done) begin
               // A disabled or protected write hands nothing to the array.
               if (wel && !prot && buf_ready) begin
                  next_push = 1'b1;
                  next_word.addr = addr;
                  next_word.data = byte_in;
                  next_pend = 1'b1;
               end
               next_addr = {addr[15:7], addr[6:0] + 7'h01};
            end
         end
         ST_STATUS: begin
            // Status shifts out after each falling clock.
            if (sck_fall) begin
               next_so = sreg[7];
               next_soe = 1'b1;
               next_sreg = {sreg[6:0], sreg[7]};
            end
         end
         ST_SKIP: begin
            // The rest of a refused frame is thrown away; only select high ends it.
            next_bit_cnt = bit_cnt;
         end
         default: next_state = ST_IDLE;
      endcase
      if (cs_n) begin
         next_soe = 1'b0;
         next_so = 1'b0;
         if (state != ST_IDLE) begin
            next_state = ST_IDLE;
            // Start only once select is high; partial bytes never program.
            if (pend && !busy) begin
               next_busy = 1'b1;
               next_tmr = 32'(PROG_CYCLES - 1);
            end
            next_pend = 1'b0;
         end
      end
   end

   // Register stage only.
   always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         state <= ST_IDLE;
         bit_cnt <= spew_pkg::BIT_CNT_RST;
         shreg <= 8'h00;
         addr <= spew_pkg::ADDR_RST;
         sreg <= 8'h00;
         wel <= 1'b0;
         pend <= 1'b0;
         busy <= 1'b0;
         tmr <= 32'h0;
         so <= 1'b0;
         soe <= 1'b0;
         push <= 1'b0;
         word <= '0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         addr <= next_addr;
         sreg <= next_sreg;
         wel <= next_wel;
         pend <= next_pend;
         busy <= next_busy;
         tmr <= next_tmr;
         so <= next_so;
         soe <= next_soe;
         push <= next_push;
         word <= next_word;
      end
   end

   // The buffer absorbs a stall by the programmer; a full buffer drops the byte.
   spew_buf2 #(
      .WIDTH($bits(spew_pkg::spew_word_t))
   ) u_buf (
      .i_clk(I_CORE_CLK),
      .i_rst(I_SYS_RST),
      .i_valid(push),
      .i_data(word),
      .o_ready(buf_ready),
      .o_valid(O_WORD_VALID),
      .o_data(O_WORD),
      .i_ready(I_WORD_READY)
   );

   assign O_SO = so;
   assign O_SO_OE = soe;
   assign O_BUSY = busy;
   assign O_WEL = wel;

   // Checks next to the logic.
   // Each one watches state that this block drives; protect_a also reads the block-protect input pins.
   busy_start_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      $rose(busy) |-> cs_n) else $error("Programming started with select low.");
   busy_ignore_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      busy && state == ST_OP && byte_done
      && (byte_in & spew_pkg::OP_MASK) == spew_pkg::OP_WRITE |=> state == ST_SKIP)
      else $error("Instruction accepted while busy.");
   wel_clear_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      $fell(busy) |-> !wel) else $error("Latch still set after programming.");
   page_wrap_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      state == ST_DATA && byte_done && !cs_n |=> addr[15:7] == $past(addr[15:7])
      && addr[6:0] == $past(addr[6:0]) + 7'h01) else $error("Page address step wrong.");
   no_prog_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      state == ST_DATA && byte_done && !wel |=> !push) else $error("Write without latch.");
   protect_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      push |-> !(I_BLOCK_PROTECT_HIGH_BIT && I_BLOCK_PROTECT_LOW_BIT)
      && !(I_BLOCK_PROTECT_HIGH_BIT && word.addr[15])
      && !(I_BLOCK_PROTECT_LOW_BIT && word.addr[15:14] == 2'h3))
      else $error("Write into protected array.");
   fresh_edge_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      state == ST_IDLE && !cs_fall |=> state == ST_IDLE) else $error("Start without edge.");
   busy_hold_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      $rose(busy) |-> busy [*8]) else $error("Busy dropped early.");
   status_bit_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      state == ST_OP && byte_done && busy
      && (byte_in & spew_pkg::OP_MASK) == spew_pkg::OP_STATUS_READ |=> sreg[0])
      else $error("Busy bit not reported.");
   so_release_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      cs_n |=> !soe) else $error("Output driven with select high.");
   write_code_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      state == ST_OP && byte_done && !busy
      && (byte_in & spew_pkg::OP_MASK) == spew_pkg::OP_WRITE |=> state == ST_ADH)
      else $error("Write code not taken.");
   addr_high_a: assert property (@(posedge I_CORE_CLK) disable iff (I_SYS_RST)
      state == ST_ADH && byte_done |=> addr[15:8] == $past(byte_in))
      else $error("Upper address byte not taken.");
endmodule

// *** spew_host_model.sv ***
/*
 * SPI mode 0 host model that drives select, clock and data toward the device.
 * Assumes the bench calls its tasks one at a time. The clock stands still between frames.
 */
`timescale 1ns/10ps
module spew_host_model (
   // Link outputs
   output logic o_cs_n,
   output logic o_sck,
   output logic o_si,
   // Link input
   input wire logic i_so
);
   // The link idles with select high and the clock low.
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_si = 1'b0;
   end

   // Every frame opens with its own select falling edge.
   task automatic frame_begin();
      o_cs_n = 1'b0;
      #16;
   endtask

   // One byte goes out MSB first while SO is taken on each rising clock.
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         o_si = tx[i];
         #16;
         o_sck = 1'b1;
         rx[i] = i_so;
         #16;
         o_sck = 1'b0;
      end
   endtask

   // Select rises in the low time after the last bit; the data line is flipped so that
   // the device cannot lean on a stale level.
   task automatic frame_end();
      #8;
      o_cs_n = 1'b1;
      o_si = ~o_si;
      #40;
   endtask
endmodule

// *** test_spi_eeprom_page_write.sv ***
/*
 * Self-checking bench for the serial EEPROM write path.
 * Assumes the host model drives the link pins and the bench acts as array programmer.
 */
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_spi_eeprom_page_write;
   localparam int P = 200;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cs_n;
   logic sck;
   logic si;
   logic so;
   logic so_oe;
   logic bp_lo = 1'b0;
   logic bp_hi = 1'b0;
   logic wvalid;
   logic wready = 1'b1;
   logic busy;
   logic wel;
   logic [7:0] st;
   spew_pkg::spew_word_t word;
   spew_pkg::spew_word_t got_q[$];
   int miscompares = 0;
   int cmp_count = 0;
   int run = 0;
   int last_run = 0;

   always #2 clk = ~clk;

   spew_host_model host (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so));

   spew_top #(.PROG_CYCLES(P)) dut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_CS_N(cs_n),
      .I_SCK(sck), .I_SI(si), .O_SO(so), .O_SO_OE(so_oe), .I_BLOCK_PROTECT_LOW_BIT(bp_lo),
      .I_BLOCK_PROTECT_HIGH_BIT(bp_hi), .O_WORD_VALID(wvalid), .O_WORD(word),
      .I_WORD_READY(wready), .O_BUSY(busy), .O_WEL(wel));

   // Collects accepted words and measures the length of each busy run.
   always @(posedge clk) begin
      if (wvalid === 1'b1 && wready === 1'b1) got_q.push_back(word);
      if (busy === 1'b1) run++;
      else if (run != 0) begin
         last_run = run;
         run = 0;
      end
   end

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic frame(input logic [7:0] b[$]);
      logic [7:0] r;
      @(negedge clk);
      host.frame_begin();
      foreach (b[i]) host.xfer(b[i], r);
      host.frame_end();
   endtask

   task automatic status(output logic [7:0] s);
      logic [7:0] r;
      @(negedge clk);
      host.frame_begin();
      host.xfer(8'h05, r);
      host.xfer(8'h00, s);
      `CHK(so_oe, 1'b1)
      host.frame_end();
      `CHK(so_oe, 1'b0)
   endtask

   // Waits out a programming cycle; a busy flag that never drops ends the run.
   task automatic prog_wait();
      for (int i = 0; i < P + 40 && busy === 1'b1; i++) @(negedge clk);
      if (busy !== 1'b0) begin
         miscompares++;
         stop_test();
      end
      repeat (2) @(negedge clk);
   endtask

   task automatic chk_word(input logic [15:0] a, input logic [7:0] d);
      spew_pkg::spew_word_t e;
      spew_pkg::spew_word_t w;
      e.addr = a;
      e.data = d;
      w = '0;
      if (got_q.size() > 0) w = got_q.pop_front();
      `CHK(w, e)
   endtask

   // A write with the latch clear after reset must leave nothing behind.
   task automatic s_no_enable();
      `CHK(wel, 1'b0)
      frame('{8'h02, 8'h00, 8'h10, 8'haa});
      repeat (20) @(posedge clk);
      `CHK(got_q.size(), 0)
      `CHK(busy, 1'b0)
   endtask

   // Page write that crosses the in-page boundary, with bit 3 of the code set.
   task automatic s_page();
      logic [7:0] r;
      frame('{8'h06});
      `CHK(wel, 1'b1)
      @(negedge clk);
      host.frame_begin();
      host.xfer(8'h0a, r);
      host.xfer(8'h12, r);
      host.xfer(8'h7e, r);
      host.xfer(8'h11, r);
      host.xfer(8'h22, r);
      host.xfer(8'h33, r);
      repeat (10) @(negedge clk);
      `CHK(busy, 1'b0)
      host.frame_end();
      `CHK(busy, 1'b1)
      status(st);
      `CHK(st, 8'hff)
      prog_wait();
      `CHK(last_run, P)
      `CHK(wel, 1'b0)
      status(st);
      `CHK(st, 8'h00)
      `CHK(got_q.size(), 3)
      chk_word(16'h127e, 8'h11);
      chk_word(16'h127f, 8'h22);
      chk_word(16'h1200, 8'h33);
   endtask

   // Instructions sent while busy are ignored.
   task automatic s_busy_ignore();
      frame('{8'h06});
      frame('{8'h02, 8'h00, 8'h00, 8'h5a});
      frame('{8'h06});
      frame('{8'h02, 8'h00, 8'h01, 8'h77});
      prog_wait();
      `CHK(wel, 1'b0)
      `CHK(got_q.size(), 1)
      chk_word(16'h0000, 8'h5a);
   endtask

   // Each protect level, with addresses on both sides of the boundary for the top-quarter and top-half levels.
   task automatic s_protect();
      logic [17:0] t[6] = '{{2'h0, 16'hffff}, {2'h1, 16'hc000}, {2'h1, 16'hbfff},
         {2'h2, 16'h8000}, {2'h2, 16'h7fff}, {2'h3, 16'h0000}};
      int ok[6] = '{1, 0, 1, 0, 1, 0};
      foreach (t[i]) begin
         @(negedge clk);
         bp_hi <= t[i][17];
         bp_lo <= t[i][16];
         frame('{8'h06});
         status(st);
         `CHK(st, {4'h0, t[i][17:16], 2'h2})
         frame('{8'h02, t[i][15:8], t[i][7:0], 8'hc3});
         repeat (10) @(posedge clk);
         prog_wait();
         `CHK(got_q.size(), ok[i])
         got_q.delete();
      end
      @(negedge clk);
      bp_hi <= 1'b0;
      bp_lo <= 1'b0;
   endtask

   // The programmer stalls; two words wait in the buffer, the third is dropped.
   task automatic s_stall();
      @(negedge clk);
      wready <= 1'b0;
      frame('{8'h06});
      frame('{8'h02, 8'h00, 8'h40, 8'h01, 8'h02, 8'h03});
      `CHK(wvalid, 1'b1)
      @(negedge clk);
      wready <= 1'b1;
      repeat (6) @(posedge clk);
      `CHK(got_q.size(), 2)
      chk_word(16'h0040, 8'h01);
      chk_word(16'h0041, 8'h02);
      prog_wait();
      `CHK(got_q.size(), 0)
   endtask

   // A write code inside the enable frame has no falling edge of its own.
   task automatic s_no_fall();
      frame('{8'h06, 8'h02, 8'h00, 8'h00, 8'h99});
      repeat (20) @(posedge clk);
      prog_wait();
      `CHK(got_q.size(), 0)
   endtask

   initial begin
      repeat (8) @(posedge clk);
      @(negedge clk);
      rst <= 1'b0;
      repeat (6) @(posedge clk);
      s_no_enable();
      s_page();
      s_busy_ignore();
      s_protect();
      s_stall();
      s_no_fall();
      stop_test();
   end
endmodule
